// [hw/usr8.sv]
// Eight-bit universal shift/storage register with APB access and a capture buffer.
`timescale 1ns/100ps
`include "usr8_defs.svh"

module capture_fifo #(
  parameter int WIDTH = `USR8_WIDTH,
  parameter int DEPTH = `USR8_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        push;
  logic        pop;

  assign in_ready  = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      // Pointers wrap explicitly so that a depth that is not a power of two still works.
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH-1)) ? '0 : st.wr_ptr + AW'(1);
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH-1)) ? '0 : st.rd_ptr + AW'(1);
    end
    if (push && !pop) begin
      next_st.count = st.count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_st.count = st.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // capture_fifo

// Functional notes
// - Eight storage bits, each sharing one two-way pin for load and output.
// - Select 00 hold, 01 shift right, 10 shift left, 11 load; no edge, no change.
// - Shift right: bit A takes right serial input, bits move toward H.
// - Shift left: bit H takes left serial input, bits move toward A.
// - Both selects high: the eight pin levels are captured at the clock edge.
// - Both selects high: pin drivers are off whatever the output controls say.
// - Pins driven only with both output controls low and mode not load.
// - Contents appear on enabled pins in hold and both shift modes.
// - Low clear forces storage and both end outputs low, above every mode.
// - Output controls touch only the pin drivers, never the stored state.
// - End serial outputs always driven; neighbours chain them into serial inputs.
module usr8 #(
  parameter int WIDTH      = `USR8_WIDTH,
  parameter int FIFO_DEPTH = `USR8_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Device pins, inputs.
  input  wire usr8_pkg::pin_in_t     pins,
  // Device pins, outputs.
  output logic [7:0]                 shared_pin_out,
  output logic [7:0]                 shared_pin_oe_n,
  output logic                       low_end_serial_output,
  output logic                       high_end_serial_output
);
  import usr8_pkg::*;

  typedef struct packed {
    pin_in_t    sync1;
    pin_in_t    sync2;
    pin_in_t    sync3;
    pin_in_t    filt;
    logic       clock_prev;
    logic [7:0] store;
    logic       drive;
    logic       op_pending;
    mode_t      op_mode;
    logic [7:0] op_data;
    logic       op_left;
    logic       op_right;
    logic       capture_en;
    logic       ack;
    logic       err;
    logic [31:0] rd_data;
  } state_t;

  state_t     st;
  state_t     next_st;
  mode_t      pin_mode;
  logic       clock_rise;
  logic       wr_commit;
  logic       rd_commit;
  logic       sw_clear;
  logic       sw_step;
  logic       clear_active;
  logic       step_event;
  logic       can_exec;
  logic [7:0] op_result;
  logic       push_valid;
  logic       push_ready;
  logic       pop_valid;
  logic       pop_ready;
  logic [7:0] pop_data;
  logic [31:0] status_word;

  capture_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) capture_fifo_i (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (op_result),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // The mode and edge come from the filtered pin levels, so data and selects stay aligned.
  assign pin_mode   = mode_t'({st.filt.function_select_high, st.filt.function_select_low});
  assign clock_rise = st.filt.shift_clock & ~st.clock_prev;

  // APB handshake: setup latches the answer, the following access cycle completes it.
  assign pready    = psel & penable & st.ack;
  assign pslverr   = pready & st.err;
  assign prdata    = st.rd_data;
  assign wr_commit = pready & pwrite;
  assign rd_commit = pready & ~pwrite;
  assign pop_ready = rd_commit & (paddr == `USR8_OFS_FIFO_DATA);

  assign sw_clear = wr_commit & (paddr == `USR8_OFS_CTRL) & pwdata[`USR8_CTRL_SW_CLEAR];
  assign sw_step  = wr_commit & (paddr == `USR8_OFS_CTRL) & pwdata[`USR8_CTRL_SW_STEP];

  // Clear works from the filtered pin, so a glitch sampled at only one clock edge is ignored.
  assign clear_active = ~st.filt.clear_n | sw_clear;
  assign step_event   = clock_rise | sw_step;

  // A stalled operation waits for room in the buffer rather than losing its result.
  assign can_exec   = st.op_pending & (~st.capture_en | push_ready) & ~clear_active;
  assign push_valid = can_exec & st.capture_en;

  always_comb begin
    op_result = st.store;
    unique case (st.op_mode)
      MODE_HOLD: begin
        op_result = st.store;
      end
      MODE_SHIFT_RIGHT: begin
        op_result = {st.store[6:0], st.op_right};
      end
      MODE_SHIFT_LEFT: begin
        op_result = {st.op_left, st.store[7:1]};
      end
      MODE_LOAD: begin
        op_result = st.op_data;
      end
    endcase
  end

  always_comb begin
    status_word                                          = '0;
    status_word[`USR8_STAT_STORE_LSB +: 8]               = st.store;
    status_word[`USR8_STAT_MODE_LSB +: 2]                = pin_mode;
    status_word[`USR8_STAT_DRIVE]                        = st.drive;
    status_word[`USR8_STAT_PENDING]                      = st.op_pending;
    status_word[`USR8_STAT_FIFO_EMPTY]                   = ~pop_valid;
    status_word[`USR8_STAT_FIFO_FULL]                    = ~push_ready;
    status_word[`USR8_STAT_CLEARING]                     = ~st.filt.clear_n;
  end

  always_comb begin
    next_st = st;

    // Three-stage pin synchroniser; a level counts once stages two and three agree.
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    next_st.filt  = pin_in_t'((st.sync2 & st.sync3) | (st.filt & (st.sync2 ^ st.sync3)));
    next_st.clock_prev = st.filt.shift_clock;

    // Drivers depend on output controls and mode only, never on what is stored.
    next_st.drive = ~st.filt.output_control_n_first & ~st.filt.output_control_n_second
                    & (pin_mode != MODE_LOAD);

    // Execute a waiting operation, then accept a new edge if the slot is free.
    if (can_exec) begin
      next_st.store      = op_result;
      next_st.op_pending = 1'b0;
    end
    if (step_event && (!st.op_pending || can_exec)) begin
      next_st.op_pending = 1'b1;
      next_st.op_mode    = pin_mode;
      next_st.op_data    = st.filt.shared_pin_in;
      next_st.op_left    = st.filt.left_serial_input;
      next_st.op_right   = st.filt.right_serial_input;
    end

    // Clear overrides everything that would touch the storage this cycle.
    if (clear_active) begin
      next_st.store      = '0;
      next_st.op_pending = 1'b0;
    end

    // APB setup phase: decode and latch the answer for the access phase.
    if (psel && !penable) begin
      next_st.ack     = 1'b1;
      next_st.err     = 1'b0;
      next_st.rd_data = '0;
      unique case (paddr)
        `USR8_OFS_CTRL: begin
          next_st.rd_data[`USR8_CTRL_CAPTURE_EN] = st.capture_en;
        end
        `USR8_OFS_STATUS: begin
          next_st.err = pwrite;
          next_st.rd_data = status_word;
        end
        `USR8_OFS_FIFO_DATA: begin
          next_st.err = pwrite;
          next_st.rd_data[7:0]              = pop_data & {8{pop_valid}};
          next_st.rd_data[`USR8_FIFO_VALID] = pop_valid;
        end
        default: begin
          next_st.err = 1'b1;
        end
      endcase
    end
    if (pready) begin
      next_st.ack = 1'b0;
    end
    if (wr_commit && paddr == `USR8_OFS_CTRL) begin
      next_st.capture_en = pwdata[`USR8_CTRL_CAPTURE_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // Output controls start inactive in every stage, so the pins stay released after reset.
      st                              <= '0;
      st.sync1.output_control_n_first  <= 1'b1;
      st.sync1.output_control_n_second <= 1'b1;
      st.sync2.output_control_n_first  <= 1'b1;
      st.sync2.output_control_n_second <= 1'b1;
      st.sync3.output_control_n_first  <= 1'b1;
      st.sync3.output_control_n_second <= 1'b1;
      st.filt.output_control_n_first   <= 1'b1;
      st.filt.output_control_n_second  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Pin data comes straight from the storage flip-flops.
  assign shared_pin_out  = st.store;
  assign shared_pin_oe_n = {8{~st.drive}};

  // End outputs are never released; clear pulls them low at once.
  assign low_end_serial_output  = st.store[0] & ~clear_active;
  assign high_end_serial_output = st.store[7] & ~clear_active;

endmodule // usr8

// [shared/usr8_defs.svh]
// Offsets, field positions, reset values and counts of the eight-bit universal shift register.
`ifndef USR8_DEFS_SVH
`define USR8_DEFS_SVH

// Register byte offsets on the APB side.
`define USR8_OFS_CTRL          8'h00
`define USR8_OFS_STATUS        8'h04
`define USR8_OFS_FIFO_DATA     8'h08

// Control register fields.
`define USR8_CTRL_CAPTURE_EN   0
`define USR8_CTRL_SW_CLEAR     1
`define USR8_CTRL_SW_STEP      2
`define USR8_CTRL_RESET        32'h0000_0000

// Status register fields.
`define USR8_STAT_STORE_LSB    0
`define USR8_STAT_MODE_LSB     8
`define USR8_STAT_DRIVE        10
`define USR8_STAT_PENDING      11
`define USR8_STAT_FIFO_EMPTY   12
`define USR8_STAT_FIFO_FULL    13
`define USR8_STAT_CLEARING     14

// Capture data register fields.
`define USR8_FIFO_VALID        8

// Storage width and capture depth.
`define USR8_WIDTH             8
`define USR8_FIFO_DEPTH        32

`endif

// [shared/usr8_pkg.sv]
// Types shared by the eight-bit universal shift register, its checker and its bench.
package usr8_pkg;

  // Function select code, high bit first.
  typedef enum logic [1:0] {
    MODE_HOLD        = 2'b00,
    MODE_SHIFT_RIGHT = 2'b01,
    MODE_SHIFT_LEFT  = 2'b10,
    MODE_LOAD        = 2'b11
  } mode_t;

  // Every level that arrives on a device pin, bit 0 of data is the first shared pin.
  typedef struct packed {
    logic       shift_clock;
    logic       clear_n;
    logic       function_select_high;
    logic       function_select_low;
    logic       output_control_n_first;
    logic       output_control_n_second;
    logic       left_serial_input;
    logic       right_serial_input;
    logic [7:0] shared_pin_in;
  } pin_in_t;

endpackage

// [testbench/usr8_sva.sv]
// Port checker for the eight-bit shift register.
`timescale 1ns/100ps
module usr8_sva (
  // Clock, reset and APB.
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Device pins.
  input wire usr8_pkg::pin_in_t pins,
  input wire logic [7:0]        shared_pin_out,
  input wire logic [7:0]        shared_pin_oe_n,
  input wire logic              low_end_serial_output,
  input wire logic              high_end_serial_output
);
  import usr8_pkg::*;
  // Pin levels pass a synchroniser, so every pin-level check waits for a level held several cycles.
  logic [3:0] ld_c, en_c, cl_c, hi_c, ev_c;
  logic       ld, en, ev;
  function automatic logic [3:0] up(input logic [3:0] c, input logic k);
    return k ? c + {3'h0, c != 4'hF} : 4'h0;
  endfunction
  assign ld = pins.function_select_high & pins.function_select_low;
  assign en = !pins.output_control_n_first & !pins.output_control_n_second & !ld;
  assign ev = (psel & (paddr == 8'h00 | paddr == 8'h08)) | !pins.clear_n | pins.shift_clock;
  always_ff @(posedge clk) begin
    if (rst) begin
      {ld_c, en_c, cl_c, hi_c, ev_c} <= 20'h0;
    end else begin
      ld_c <= up(ld_c, ld);
      en_c <= up(en_c, en);
      cl_c <= up(cl_c, !pins.clear_n);
      hi_c <= up(hi_c, pins.clear_n);
      ev_c <= up(ev_c, !ev);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_oe_uniform: assert property (shared_pin_oe_n == 8'h00 || shared_pin_oe_n == 8'hFF)
    else $error("enables differ");
  a_load_off: assert property (ld_c >= 4'h6 |-> shared_pin_oe_n == 8'hFF)
    else $error("driving in load");
  a_drive_on: assert property (en_c >= 4'h7 |-> shared_pin_oe_n == 8'h00)
    else $error("not driving");
  a_clear_low: assert property (cl_c >= 4'h6 |-> {shared_pin_out, low_end_serial_output,
    high_end_serial_output} == 10'h000) else $error("clear ignored");
  // A software clear gates the end outputs during its own completing cycle.
  a_end_track: assert property (hi_c >= 4'h6 && !(pready && paddr == 8'h00) |->
    low_end_serial_output == shared_pin_out[0]
    && high_end_serial_output == shared_pin_out[7]) else $error("end output wrong");
  a_store_cause: assert property (ev_c >= 4'hA |-> $stable(shared_pin_out))
    else $error("store changed");
  a_apb_ready: assert property (s_setup |=> pready)
    else $error("no ready");
  a_bad_addr: assert property (s_setup ##0 paddr > 8'h08 |=> pslverr && prdata == 32'h0)
    else $error("no error");
endmodule // usr8_sva

bind usr8 usr8_sva usr8_sva_i (.clk, .rst, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .pins,
  .shared_pin_out, .shared_pin_oe_n, .low_end_serial_output, .high_end_serial_output);

// [testbench/usr8_bus_model.sv]
// Bus logic on the far side of the shared data pins.
`timescale 1ns/100ps
module usr8_bus_model (
  // Clock.
  input wire logic       clk,
  // Bench controls.
  input wire logic       drive_en,
  input wire logic [7:0] drive_val,
  // Device side and resolved wire.
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe_n,
  output logic [7:0]     wire_lvl
);
  logic [7:0] last = 8'h00;
  // A floating line shows a level that flips each cycle, so stale data never looks valid.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!dev_oe_n[i]) wire_lvl[i] = dev_out[i];
      else if (drive_en) wire_lvl[i] = drive_val[i];
      else wire_lvl[i] = ~last[i];
    end
  end
  always_ff @(posedge clk) begin
    last <= wire_lvl;
  end
endmodule // usr8_bus_model

// [testbench/usr8_bench.sv]
// Self-checking bench for the eight-bit shift register.
`timescale 1ns/100ps
`include "usr8_defs.svh"
module usr8_bench;
  import usr8_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, drv_en, err, lo, hi;
  logic [7:0]  paddr, drv_val, pin_out, oe_n, wire_lvl;
  logic [31:0] pwdata, prdata, rd;
  pin_in_t     pin_drv, pins;
  int          error_cnt, tests_run;
  always_comb begin
    pins = pin_drv;
    pins.shared_pin_in = wire_lvl;
  end
  usr8 usr8_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins,
    .shared_pin_out(pin_out), .shared_pin_oe_n(oe_n), .low_end_serial_output(lo), .high_end_serial_output(hi));
  usr8_bus_model usr8_bus_model_i (.clk, .drive_en(drv_en), .drive_val(drv_val), .dev_out(pin_out),
    .dev_oe_n(oe_n), .wire_lvl);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // The answer is taken at the rising edge at which pready is sampled high, and only then released.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [1:0] m, input logic [1:0] g, input logic s);
    @(posedge clk);
    {pin_drv.function_select_high, pin_drv.function_select_low} <= m;
    {pin_drv.output_control_n_first, pin_drv.output_control_n_second} <= g;
    pin_drv.right_serial_input <= s;
    pin_drv.left_serial_input <= ~s;
    drv_en <= &m;
    repeat (8) @(posedge clk);
    pin_drv.shift_clock <= 1'b1;
    repeat (4) @(posedge clk);
    pin_drv.shift_clock <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_basic();
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_1000);
    drv_val <= 8'hA5;
    op(2'b11, 2'b00, 1'b0);
    chk({24'h0, oe_n}, 32'h0000_00FF);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_13A5);
  endtask
  task automatic t_shift();
    op(2'b01, 2'b00, 1'b1);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_154B);
    chk({22'h0, lo, hi, wire_lvl}, 32'h0000_024B);
    op(2'b10, 2'b00, 1'b1);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_1625);
    chk({22'h0, lo, hi, wire_lvl}, 32'h0000_0225);
  endtask
  task automatic t_offout();
    op(2'b01, 2'b01, 1'b0);
    chk({24'h0, oe_n}, 32'h0000_00FF);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_114A);
    op(2'b00, 2'b10, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `USR8_OFS_STATUS, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_104A);
  endtask
  task automatic t_clear();
    pin_drv.clear_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({22'h0, lo, hi, pin_out}, 32'h0);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_5000);
    pin_drv.clear_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // Software step and software clear act like a pin clock edge and a clear pulse.
  task automatic t_soft();
    op(2'b01, 2'b11, 1'b1);
    apb(1'b1, `USR8_OFS_CTRL, 32'h4);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_1103);
    apb(1'b1, `USR8_OFS_CTRL, 32'h2);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_1100);
  endtask
  task automatic t_fifo();
    drv_val <= 8'h3C;
    apb(1'b1, `USR8_OFS_CTRL, 32'h1);
    op(2'b11, 2'b11, 1'b0);
    for (int i = 0; i < 32; i++) begin
      op(2'b00, 2'b11, 1'b0);
    end
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_283C);
    repeat (33) begin
      apb(1'b0, `USR8_OFS_FIFO_DATA, 32'h0);
      chk(rd, 32'h0000_013C);
    end
    apb(1'b0, `USR8_OFS_FIFO_DATA, 32'h0);
    chk({31'h0, rd[8]}, 32'h0);
    apb(1'b0, `USR8_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_103C);
  endtask
  initial begin
    {psel, penable, pwrite, drv_en, paddr, pwdata, drv_val} = '0;
    pin_drv = '0;
    pin_drv.clear_n = 1'b1;
    pin_drv.output_control_n_first = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_basic();
    t_shift();
    t_offout();
    t_clear();
    t_soft();
    t_fifo();
    end_sim();
  end
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule // usr8_bench
